// File: hw/cdx_cfg.svh
// Constants for the complement / decrement execution slice.
`ifndef CDX_CFG_SVH
`define CDX_CFG_SVH

// Widths
`define CDX_DATA_W 8
`define CDX_INSTR_W 12
`define CDX_FADDR_W 5
`define CDX_OPC_W 6

// Instruction word fields
`define CDX_OPC_HI 11
`define CDX_OPC_LO 6
`define CDX_DEST_BIT 5
`define CDX_FADDR_HI 4
`define CDX_FADDR_LO 0

// Opcode field values (bits 11:6)
`define CDX_OPC_COMPLEMENT 6'h09
`define CDX_OPC_DECREMENT 6'h03

// Destination select values
`define CDX_DEST_ACC 1'h0
`define CDX_DEST_FILE 1'h1

// Arithmetic constants
`define CDX_DEC_STEP 8'h01
`define CDX_BYTE_ZERO 8'h00

// Reset values
`define CDX_RST_ACC 8'h00
`define CDX_RST_ZERO 1'h0
`define CDX_RST_INSTR 12'h000
`define CDX_RST_FADDR 5'h00

// Timing: one instruction cycle spans several system clocks
`define CDX_CLK_NS 50
`define CDX_ICYC_NS 200
`define CDX_PHASES ((`CDX_ICYC_NS + `CDX_CLK_NS - 1) / `CDX_CLK_NS)
`define CDX_PHASE_W 2
`define CDX_PHASE_LAST 2'((`CDX_PHASES) - 1)
`define CDX_PHASE_ZERO 2'h0
`define CDX_PHASE_STEP 2'h1

`endif

// File: hw/cdx_pkg.sv
// Types shared by the complement / decrement execution slice.
`include "cdx_cfg.svh"

package cdx_pkg;
    typedef logic [`CDX_DATA_W-1:0] cdx_byte_t;
    typedef logic [`CDX_INSTR_W-1:0] cdx_instr_t;
    typedef logic [`CDX_FADDR_W-1:0] cdx_faddr_t;
    typedef logic [`CDX_OPC_W-1:0] cdx_opc_t;
    typedef logic [`CDX_PHASE_W-1:0] cdx_phase_t;

    // Operation chosen by the decoder
    typedef enum logic [1:0] {
        CDX_OP_NONE,
        CDX_OP_COMPLEMENT,
        CDX_OP_DECREMENT
    } cdx_op_t;

    // Sequencer states, one per phase of an instruction cycle
    typedef enum logic [1:0] {
        CDX_ST_IDLE,
        CDX_ST_READ,
        CDX_ST_EXEC,
        CDX_ST_WRITE
    } cdx_state_t;
endpackage

// File: hw/cdx_alu_if.sv
// Interface between the sequencer and the arithmetic unit.
`timescale 1ns/1ns

interface cdx_alu_if;
    import cdx_pkg::*;
    logic calc_en;
    cdx_op_t op;
    cdx_byte_t operand;
    cdx_byte_t result;
    logic zero;

    modport core (output calc_en, output op, output operand, input result, input zero);
    modport alu (input calc_en, input op, input operand, output result, output zero);
endinterface

// File: hw/cdx_alu.sv
// Registered arithmetic unit: complement or decrement one byte.
`timescale 1ns/1ns
`include "cdx_cfg.svh"

module cdx_alu (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    // Sequencer side
    cdx_alu_if.alu alu
);
    import cdx_pkg::*;

    cdx_byte_t result_nxt;

    // Next result; an unknown op passes the operand untouched
    always_comb begin
        case (alu.op)
            CDX_OP_COMPLEMENT: result_nxt = ~alu.operand;
            CDX_OP_DECREMENT: result_nxt = alu.operand - `CDX_DEC_STEP;
            default: result_nxt = alu.operand;
        endcase
    end

    // Result and zero test are held until the next calculation
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            alu.result <= `CDX_BYTE_ZERO;
            alu.zero <= `CDX_RST_ZERO;
        end else if (alu.calc_en) begin
            alu.result <= result_nxt;
            alu.zero <= (result_nxt == `CDX_BYTE_ZERO);
        end
    end
endmodule

// File: hw/cdx_exec.sv
// Execution slice for the complement-file and decrement-file instructions.
`timescale 1ns/1ns
`include "cdx_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
module cdx_exec (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    // Instruction from the decoder
    input wire cdx_pkg::cdx_instr_t i_instr,
    input wire logic i_instr_valid,
    output logic o_instr_ready,
    output logic o_cycle_start,
    output logic o_instr_foreign,
    // File register port
    output cdx_pkg::cdx_faddr_t o_fr_addr,
    output logic o_fr_re,
    input wire cdx_pkg::cdx_byte_t i_fr_rdata,
    output cdx_pkg::cdx_byte_t o_fr_wdata,
    output logic o_fr_we,
    // Working accumulator and zero flag
    output cdx_pkg::cdx_byte_t o_acc,
    output logic o_zero_flag,
    output logic o_zero_we,
    output logic o_done
);
    import cdx_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    // Divider and sequencer
    cdx_phase_t phase_r;
    logic cyc_en;
    cdx_state_t state_r;
    cdx_state_t state_nxt;
    // Instruction held for the cycle, and its operand
    cdx_op_t op_r;
    logic dest_r;
    cdx_faddr_t faddr_r;
    cdx_byte_t operand_r;
    // Results held for the rest of the core
    cdx_byte_t acc_r;
    logic zero_r;
    // Decode of the word on offer
    cdx_op_t op_dec;
    logic take;

    cdx_alu_if alu_bus ();

    ////////////////////////////////////////////////////////////////////////////
    // Decoding

    // Opcode field to operation; shared by the accept path and the foreign flag
    function automatic cdx_op_t decode_op(input cdx_instr_t instr);
        cdx_opc_t opc;
        opc = instr[`CDX_OPC_HI:`CDX_OPC_LO];
        if (opc == `CDX_OPC_COMPLEMENT) begin
            decode_op = CDX_OP_COMPLEMENT;
        end else if (opc == `CDX_OPC_DECREMENT) begin
            decode_op = CDX_OP_DECREMENT;
        end else begin
            decode_op = CDX_OP_NONE;
        end
    endfunction

    // Decode of the word on offer; latched only when taken
    assign op_dec = decode_op(i_instr);

    ////////////////////////////////////////////////////////////////////////////
    // Instruction cycle divider

    // The core runs one instruction per four system clocks; the divider
    // gives a one-clock enable at the boundary instead of a second clock
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            phase_r <= `CDX_PHASE_ZERO;
        end else if (phase_r == `CDX_PHASE_LAST) begin
            phase_r <= `CDX_PHASE_ZERO;
        end else begin
            phase_r <= phase_r + `CDX_PHASE_STEP;
        end
    end

    // Boundary pulse, last phase of each instruction cycle
    assign cyc_en = (phase_r == `CDX_PHASE_LAST);
    assign o_cycle_start = cyc_en;

    // A word is taken only on the boundary and only if it is ours;
    // foreign opcodes are left to the rest of the core
    assign take = cyc_en && i_instr_valid && (state_r == CDX_ST_IDLE)
        && (op_dec != CDX_OP_NONE);

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer

    // The walk read, exec, write fills exactly the three clocks between two
    // boundaries, so an instruction never spills into the next cycle
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            CDX_ST_IDLE: begin
                if (take) begin
                    state_nxt = CDX_ST_READ;
                end
            end
            CDX_ST_READ: begin
                state_nxt = CDX_ST_EXEC;
            end
            CDX_ST_EXEC: begin
                state_nxt = CDX_ST_WRITE;
            end
            CDX_ST_WRITE: begin
                state_nxt = CDX_ST_IDLE;
            end
            default: begin
                state_nxt = CDX_ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            state_r <= CDX_ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Instruction latch

    // Operation, destination and address are held for the whole cycle so the
    // decoder may move on to its next word at once
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            op_r <= CDX_OP_NONE;
            dest_r <= `CDX_DEST_ACC;
            faddr_r <= `CDX_RST_FADDR;
        end else if (take) begin
            op_r <= op_dec;
            dest_r <= i_instr[`CDX_DEST_BIT];
            faddr_r <= i_instr[`CDX_FADDR_HI:`CDX_FADDR_LO];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Operand fetch

    // Read data is sampled at the end of the read phase; the file port
    // must answer combinationally within that one clock
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            operand_r <= `CDX_BYTE_ZERO;
        end else if (state_r == CDX_ST_READ) begin
            operand_r <= i_fr_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Arithmetic unit

    assign alu_bus.calc_en = (state_r == CDX_ST_EXEC);
    assign alu_bus.op = op_r;
    assign alu_bus.operand = operand_r;

    cdx_alu u_alu (
        .i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst),
        .alu(alu_bus)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Result routing

    // Accumulator takes the result only when the file is not the target
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            acc_r <= `CDX_RST_ACC;
        end else if ((state_r == CDX_ST_WRITE) && (dest_r == `CDX_DEST_ACC)) begin
            acc_r <= alu_bus.result;
        end
    end

    // Zero flag is the only status bit this slice touches
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            zero_r <= `CDX_RST_ZERO;
        end else if (state_r == CDX_ST_WRITE) begin
            zero_r <= alu_bus.zero;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    // Ready handshake output is combinational from the state
    assign o_instr_ready = (state_r == CDX_ST_IDLE);
    // Foreign words are flagged so the rest of the core knows to run them
    assign o_instr_foreign = cyc_en && i_instr_valid && (op_dec == CDX_OP_NONE);
    // The file port has only this one clock to answer the read
    assign o_fr_re = (state_r == CDX_ST_READ);
    // Same address is used for the read and the write back
    assign o_fr_addr = faddr_r;
    assign o_fr_wdata = alu_bus.result;
    // No file write at all when the accumulator is the target
    assign o_fr_we = (state_r == CDX_ST_WRITE) && (dest_r == `CDX_DEST_FILE);
    // Both ops update the zero flag, so its strobe is the write clock
    assign o_zero_we = (state_r == CDX_ST_WRITE);
    assign o_done = (state_r == CDX_ST_WRITE);
    // Data outputs come straight from their flops
    assign o_acc = acc_r;
    assign o_zero_flag = zero_r;
endmodule

// File: test/cdx_exec_chk.sv
// Port-level assertion checker for the complement / decrement slice.
`timescale 1ns/1ns
`include "cdx_cfg.svh"

module cdx_exec_chk (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    // Instruction side
    input wire cdx_pkg::cdx_instr_t i_instr,
    input wire logic i_instr_valid,
    input wire logic o_instr_ready,
    input wire logic o_cycle_start,
    // File register side
    input wire cdx_pkg::cdx_faddr_t o_fr_addr,
    input wire logic o_fr_re,
    input wire cdx_pkg::cdx_byte_t i_fr_rdata,
    input wire cdx_pkg::cdx_byte_t o_fr_wdata,
    input wire logic o_fr_we,
    // Accumulator and flag
    input wire cdx_pkg::cdx_byte_t o_acc,
    input wire logic o_zero_flag,
    input wire logic o_zero_we,
    input wire logic o_done
);
    logic take;
    logic is_comp;
    cdx_pkg::cdx_faddr_t in_faddr;
    logic in_dest;

    ////////////////////////////////////////////////////////////////////////////////
    // Accepted word: boundary, offered, idle and one of our two opcodes
    assign is_comp = i_instr[11:6] == `CDX_OPC_COMPLEMENT;
    assign take = o_cycle_start && i_instr_valid && o_instr_ready
        && (is_comp || i_instr[11:6] == `CDX_OPC_DECREMENT);

    // Address and destination fields kept as signals for $past
    assign in_faddr = i_instr[`CDX_FADDR_HI:`CDX_FADDR_LO];
    assign in_dest = i_instr[`CDX_DEST_BIT];

    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencing and results
    read_follows_a: assert property (take |=> o_fr_re && o_fr_addr == $past(in_faddr))
        else $error("no read of the taken address");
    done_timing_a: assert property (take |-> ##3 o_done)
        else $error("done not three clocks after take");
    result_value_a: assert property (o_done |-> o_fr_wdata == ($past(is_comp, 3)
        ? ~$past(i_fr_rdata, 2) : $past(i_fr_rdata, 2) - 8'h01))
        else $error("wrong result byte");
    dest_select_a: assert property (o_done |-> o_fr_we == $past(in_dest, 3))
        else $error("file write does not follow destination bit");
    write_with_done_a: assert property (o_fr_we |-> o_done)
        else $error("file write outside write clock");
    acc_load_a: assert property (o_done && !o_fr_we |=> o_acc == $past(o_fr_wdata))
        else $error("accumulator not loaded");
    acc_hold_a: assert property (!o_done || o_fr_we |=> $stable(o_acc))
        else $error("accumulator changed unexpectedly");
    zero_flag_a: assert property (o_zero_we |=> o_zero_flag == ($past(o_fr_wdata) == 8'h00))
        else $error("zero flag wrong");
    zero_hold_a: assert property (!o_zero_we |=> $stable(o_zero_flag))
        else $error("zero flag changed without update");
    zero_update_a: assert property (o_zero_we == o_done)
        else $error("zero flag strobe not with done");
endmodule

bind cdx_exec cdx_exec_chk chk_u (.i_clk_sys, .i_sys_rst, .i_instr, .i_instr_valid,
    .o_instr_ready, .o_cycle_start, .o_fr_addr, .o_fr_re, .i_fr_rdata, .o_fr_wdata,
    .o_fr_we, .o_acc, .o_zero_flag, .o_zero_we, .o_done);

// File: test/testbench.sv
// Self-checking bench for the complement / decrement slice.
`timescale 1ns/1ns
`include "cdx_cfg.svh"

module testbench;
    import cdx_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    cdx_instr_t instr = 12'h000;
    logic vld = 1'b0;
    cdx_byte_t rdata = 8'h00;
    logic rdy, cst, frn, re, we, zf, zwe, done;
    cdx_faddr_t addr;
    cdx_byte_t wdata, acc;
    cdx_byte_t exp_acc = 8'h00;
    int error_cnt = 0;
    int check_count = 0;

    cdx_exec dut_u (.i_clk_sys(clk), .i_sys_rst(rst), .i_instr(instr), .i_instr_valid(vld),
        .o_instr_ready(rdy), .o_cycle_start(cst), .o_instr_foreign(frn),
        .o_fr_addr(addr), .o_fr_re(re), .i_fr_rdata(rdata), .o_fr_wdata(wdata),
        .o_fr_we(we), .o_acc(acc), .o_zero_flag(zf), .o_zero_we(zwe), .o_done(done));

    // Free-running system clock, 50 ns period
    initial begin
        forever #25 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers: inputs move 5 ns after the edge, so outputs are settled there
    task automatic step();
        @(posedge clk);
        #5;
    endtask

    task automatic chk_byte(input cdx_byte_t got, input cdx_byte_t exp, input string msg);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string msg);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t %s got %b exp %b", $time, msg, got, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("errors %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // One instruction; read data is scrambled after the read clock so a late sample shows
    task automatic run_op(input cdx_opc_t opc, input logic d, input cdx_faddr_t f,
        input cdx_byte_t src, input cdx_byte_t res);
        int n;
        n = 0;
        while (cst !== 1'b1 && n < 8) begin
            step();
            n++;
        end
        instr = {opc, d, f};
        vld = 1'b1;
        rdata = src;
        step();
        vld = 1'b0;
        chk_bit(re, 1'b1, "read strobe");
        chk_byte({3'h0, addr}, {3'h0, f}, "address");
        chk_bit(rdy, 1'b0, "busy");
        step();
        rdata = ~src;
        step();
        chk_bit(done, 1'b1, "done");
        chk_bit(we, d, "file write");
        chk_bit(zwe, 1'b1, "zero update");
        chk_byte(wdata, res, "result");
        if (!d) exp_acc = res;
        step();
        chk_byte(acc, exp_acc, "accumulator");
        chk_bit(zf, res == 8'h00, "zero flag");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic sc_back_to_back();
        run_op(`CDX_OPC_COMPLEMENT, 1'b0, 5'h03, 8'h13, 8'hec);
        run_op(`CDX_OPC_DECREMENT, 1'b1, 5'h03, 8'h01, 8'h00);
    endtask

    task automatic sc_boundaries();
        run_op(`CDX_OPC_DECREMENT, 1'b0, 5'h1f, 8'h00, 8'hff);
        run_op(`CDX_OPC_COMPLEMENT, 1'b1, 5'h00, 8'hff, 8'h00);
        run_op(`CDX_OPC_DECREMENT, 1'b0, 5'h11, 8'h80, 8'h7f);
    endtask

    // Foreign opcode, then an off-boundary offer: neither may start a cycle
    task automatic sc_refused();
        instr = {6'h0b, 1'b0, 5'h02};
        vld = 1'b1;
        #1;
        chk_bit(frn, 1'b1, "foreign flag");
        step();
        instr = {`CDX_OPC_COMPLEMENT, 1'b0, 5'h02};
        chk_bit(re, 1'b0, "foreign read");
        step();
        vld = 1'b0;
        chk_bit(re, 1'b0, "off-boundary read");
        step();
        step();
        chk_byte(acc, exp_acc, "accumulator kept");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence: reset held three clocks
    initial begin
        repeat (3) @(posedge clk);
        #5;
        rst = 1'b0;
        chk_byte(acc, `CDX_RST_ACC, "reset accumulator");
        chk_bit(zf, `CDX_RST_ZERO, "reset zero flag");
        sc_back_to_back();
        sc_refused();
        sc_boundaries();
        report_and_stop();
    end

    // Watchdog: the run needs well under a hundred instruction cycles
    initial begin
        #100000;
        error_cnt++;
        report_and_stop();
    end
endmodule
